/* cfq_engine.sv */
// protocol engine stand-in: store and consume pulses per queue
// assumes send is called right after a rising clock edge
`timescale 1ns/1ns

module cfq_engine
  import cfq_pkg::*;
(
  // clock
  input  wire logic          clk_i,
  // pulses toward the queue block
  output logic [CFQ_NQ-1:0]  event_o
);
  initial event_o = '0;

  // prompt holds the mask n cycles, slow leaves a gap after each pulse
  task automatic send(input logic [CFQ_NQ-1:0] mask, input int n, input bit slow);
    if (slow) begin
      repeat (n) begin
        event_o <= mask;
        @(posedge clk_i);
        event_o <= '0;
        @(posedge clk_i);
      end
    end else begin
      event_o <= mask;
      repeat (n) @(posedge clk_i);
      event_o <= '0;
      @(posedge clk_i);
    end
  endtask
endmodule

/* cfq_pkg.sv */
// package for the message queue status and user address block
// assumes one module clock, synchronous active-low reset, plain register port

package cfq_pkg;

  // ----------------------------------------------------------------
  // queue numbering and sizes
  // ----------------------------------------------------------------
  localparam int          CFQ_NQ       = 17;      // event queue, fifos 1..15, transmit queue
  localparam int          CFQ_Q_EVQ    = 0;
  localparam int          CFQ_Q_TXQ    = 16;
  localparam int          CFQ_PTR_W    = 5;       // slot index, depth up to 32
  localparam int          CFQ_CNT_W    = 6;       // occupancy 0..32
  localparam int          CFQ_ADDR_W   = 12;
  localparam int          CFQ_IRQ_W    = 4;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CFQ_ADR_MODE      = 12'h000;
  localparam logic [11:0] CFQ_ADR_EVQ_STAT  = 12'h008;
  localparam logic [11:0] CFQ_ADR_IRQ_STAT  = 12'h010;
  localparam logic [11:0] CFQ_ADR_IRQ_CLR   = 12'h014;
  localparam logic [11:0] CFQ_ADR_IRQ_EN    = 12'h018;
  localparam logic [11:0] CFQ_ADR_CTRL_BASE = 12'h100;   // plus 4 * queue number
  localparam logic [11:0] CFQ_ADR_UA_BASE   = 12'h200;   // plus 4 * queue number

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          CFQ_MODE_LSB   = 0;
  localparam int          CFQ_CTL_DEPTH  = 24;
  localparam int          CFQ_CTL_FLUSH  = 10;
  localparam int          CFQ_CTL_ADV    = 8;
  localparam int          CFQ_CTL_DIR    = 7;
  localparam int          CFQ_ST_NE      = 0;
  localparam int          CFQ_ST_HALF    = 1;
  localparam int          CFQ_ST_FULL    = 2;
  localparam int          CFQ_ST_OVF     = 3;
  localparam int          CFQ_IRQ_OVF    = 0;
  localparam int          CFQ_IRQ_NE     = 1;
  localparam int          CFQ_IRQ_FULL   = 2;
  localparam int          CFQ_IRQ_FLUSH  = 3;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  CFQ_MODE_CONFIG = 3'h4;
  localparam logic [2:0]  CFQ_MODE_RST    = 3'h4;
  localparam logic [4:0]  CFQ_DEPTH_RST   = 5'h00;
  localparam logic [3:0]  CFQ_IRQ_RST     = 4'h0;

  // ----------------------------------------------------------------
  // state of one queue's pointers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CFQ_PTR_W-1:0] head;
    logic [CFQ_PTR_W-1:0] tail;
    logic [CFQ_CNT_W-1:0] count;
  } cfq_qstate_t;

endpackage

/* cfq_queue.sv */
// head, tail and occupancy of one message queue
// assumes push and pop are one-cycle pulses and flush overrides both
`timescale 1ns/1ns

module cfq_queue
  import cfq_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // control
  input  wire logic [CFQ_PTR_W-1:0] depth_field_i,
  input  wire logic                 flush_i,
  input  wire logic                 push_i,
  input  wire logic                 pop_i,
  // state
  output logic      [CFQ_PTR_W-1:0] head_o,
  output logic      [CFQ_PTR_W-1:0] tail_o,
  output logic      [CFQ_CNT_W-1:0] count_o,
  output logic                      full_o,
  output logic                      drop_o
);

  cfq_qstate_t st_r;
  cfq_qstate_t st_nxt;
  logic        do_push;
  logic        do_pop;

  // ----------------------------------------------------------------
  // pointer step with wrap at the programmed depth
  // ----------------------------------------------------------------
  function automatic logic [CFQ_PTR_W-1:0] step_f(input logic [CFQ_PTR_W-1:0] p,
                                                  input logic [CFQ_PTR_W-1:0] last);
    step_f = (p == last) ? '0 : CFQ_PTR_W'(p + 1'b1);
  endfunction

  // depth is field plus one, so full means count above the field
  assign full_o  = ({1'b0, st_r.count} > {2'b00, depth_field_i});
  assign do_push = push_i & ~full_o & ~flush_i;
  assign do_pop  = pop_i & (st_r.count != '0) & ~flush_i;
  assign drop_o  = push_i & full_o & ~flush_i;

  // next pointer state
  always_comb begin
    st_nxt = st_r;
    if (flush_i) begin
      st_nxt = '0;
    end else begin
      if (do_push) begin
        st_nxt.head = step_f(st_r.head, depth_field_i);
      end
      if (do_pop) begin
        st_nxt.tail = step_f(st_r.tail, depth_field_i);
      end
      if (do_push && !do_pop) begin
        st_nxt.count = CFQ_CNT_W'(st_r.count + 1'b1);
      end else if (do_pop && !do_push) begin
        st_nxt.count = CFQ_CNT_W'(st_r.count - 1'b1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign head_o  = st_r.head;
  assign tail_o  = st_r.tail;
  assign count_o = st_r.count;

endmodule

/* cfq_top.sv */
// status flags, user addresses and queue control for the message queues
// assumes a register master on the plain port and the protocol engine
// delivering one-cycle store or consume pulses per queue
//
// Function
// - event queue not-empty flag, bit 0, high while any entry held
// - event queue half flag, bit 1, high at or above half depth
// - event queue full flag, bit 2, high when every slot is used
// - overflow flag, bit 3, set on event into full queue, sticky
// - flushing the event queue clears the overflow flag
// - full, half and not-empty flags are live and ignore writes
// - status bits 31 to 4 read zero, writes ignored
// - one read-only user address register for each fifo 1 to 15
// - transmit fifo user address gives the head slot address
// - receive fifo user address gives the tail slot address
// - event queue user address gives its tail slot address
// - transmit queue user address gives its head slot address
// - user address registers are full 32-bit read-only words
// - tail advance request moves the queue pointer by one slot
// - flush request resets the queue, then clears itself; software polls
// - depth is field value plus one, 1 to 32 slots
// - configuration mode is code 100; depth writable only there
`timescale 1ns/1ns

module cfq_top
  import cfq_pkg::*;
#(
  parameter logic [31:0] RAM_BASE     = 32'h0000_0000,
  parameter logic [31:0] SLOT_BYTES   = 32'h0000_0048,
  parameter logic [31:0] QUEUE_STRIDE = 32'h0000_0900
)(
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // register port
  input  wire logic [CFQ_ADDR_W-1:0] ADDR_I,
  input  wire logic [31:0]           WR_DATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic      [31:0]           RD_DATA_O,
  // protocol engine side, one pulse per stored or consumed message
  input  wire logic [CFQ_NQ-1:0]     HW_EVENT_I,
  // system
  output logic                       IRQ_O,
  output logic                       CONFIG_MODE_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                          mode;
    logic [CFQ_NQ-1:0][CFQ_PTR_W-1:0]    depth;
    logic [CFQ_NQ-1:0]                   dir;
    logic [CFQ_NQ-1:0]                   flush;
    logic [CFQ_NQ-1:0]                   adv;
    logic                                ovf;
    logic                                ne_prev;
    logic                                full_prev;
    logic [CFQ_IRQ_W-1:0]                irq_stat;
    logic [CFQ_IRQ_W-1:0]                irq_en;
    logic [31:0]                         rd_data;
  } cfq_state_t;

  cfq_state_t st_r;
  cfq_state_t st_nxt;

  logic [CFQ_NQ-1:0][CFQ_PTR_W-1:0] head;
  logic [CFQ_NQ-1:0][CFQ_PTR_W-1:0] tail;
  logic [CFQ_NQ-1:0][CFQ_CNT_W-1:0] count;
  logic [CFQ_NQ-1:0]                full;
  logic [CFQ_NQ-1:0]                drop;
  logic [CFQ_NQ-1:0]                push;
  logic [CFQ_NQ-1:0]                pop;
  logic [CFQ_NQ-1:0]                dir_eff;
  logic                             evq_ne;
  logic                             evq_half;
  logic                             evq_full;
  logic                             cfg_mode;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // half flag: twice the count reaches depth (field plus one)
  function automatic logic half_f(input logic [CFQ_CNT_W-1:0] cnt,
                                  input logic [CFQ_PTR_W-1:0] fld);
    half_f = ({cnt, 1'b0} >= {2'b00, fld} + 7'h01);
  endfunction

  // message ram address of a slot of a queue
  function automatic logic [31:0] ua_f(input int unsigned              q,
                                       input logic [CFQ_PTR_W-1:0] idx);
    ua_f = 32'(RAM_BASE + 32'(q) * QUEUE_STRIDE + {27'h0, idx} * SLOT_BYTES);
  endfunction

  // register word of a per-queue bank, or no match
  function automatic logic bank_hit_f(input logic [CFQ_ADDR_W-1:0] a,
                                      input logic [CFQ_ADDR_W-1:0] base,
                                      input int unsigned             q);
    bank_hit_f = (a == 12'(base + 12'(q * 4)));
  endfunction

  // ----------------------------------------------------------------
  // direction and pointer traffic
  // ----------------------------------------------------------------

  // event queue always reads at the tail, transmit queue writes at the head
  always_comb begin
    dir_eff            = st_r.dir;
    dir_eff[CFQ_Q_EVQ] = 1'b0;
    dir_eff[CFQ_Q_TXQ] = 1'b1;
  end

  // pointer advance
  // software moves head on transmit queues, tail on receive queues
  always_comb begin
    for (int q = 0; q < CFQ_NQ; q++) begin
      push[q] = dir_eff[q] ? st_r.adv[q] : HW_EVENT_I[q];
      pop[q]  = dir_eff[q] ? HW_EVENT_I[q] : st_r.adv[q];
    end
  end

  // ----------------------------------------------------------------
  // queue pointer instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CFQ_NQ; g++) begin : g_queue
    cfq_queue u_queue (
      .clk_i         (CLK_I),
      .rst_n_i       (RST_N_I),
      .depth_field_i (st_r.depth[g]),
      .flush_i       (st_r.flush[g]),
      .push_i        (push[g]),
      .pop_i         (pop[g]),
      .head_o        (head[g]),
      .tail_o        (tail[g]),
      .count_o       (count[g]),
      .full_o        (full[g]),
      .drop_o        (drop[g])
    );
  end

  // ----------------------------------------------------------------
  // event queue live flags
  // ----------------------------------------------------------------

  assign evq_ne   = (count[CFQ_Q_EVQ] != '0);
  assign evq_half = half_f(count[CFQ_Q_EVQ], st_r.depth[CFQ_Q_EVQ]);
  assign evq_full = full[CFQ_Q_EVQ];
  assign cfg_mode = (st_r.mode == CFQ_MODE_CONFIG);

  // ----------------------------------------------------------------
  // next state: register writes, hardware updates, read data
  // ----------------------------------------------------------------
  always_comb begin
    logic [CFQ_IRQ_W-1:0] ev;
    logic [CFQ_IRQ_W-1:0] clr;
    ev     = '0;
    clr    = '0;
    st_nxt = st_r;

    // request bits clear themselves one cycle after being set
    st_nxt.flush = '0;
    st_nxt.adv   = '0;

    // mode register writes
    if (WR_I && ADDR_I == CFQ_ADR_MODE) begin
      st_nxt.mode = WR_DATA_I[CFQ_MODE_LSB +: 3];
    end

    // per-queue control writes
    for (int q = 0; q < CFQ_NQ; q++) begin
      if (WR_I && bank_hit_f(ADDR_I, CFQ_ADR_CTRL_BASE, q)) begin
        // depth and direction only in configuration mode
        if (cfg_mode) begin
          st_nxt.depth[q] = WR_DATA_I[CFQ_CTL_DEPTH +: CFQ_PTR_W];
          st_nxt.dir[q]   = WR_DATA_I[CFQ_CTL_DIR];
        end
        st_nxt.flush[q] = WR_DATA_I[CFQ_CTL_FLUSH];
        st_nxt.adv[q]   = WR_DATA_I[CFQ_CTL_ADV] & ~WR_DATA_I[CFQ_CTL_FLUSH];
      end
    end

    // only the overflow bit reacts to a status write; write 0 clears it
    if (WR_I && ADDR_I == CFQ_ADR_EVQ_STAT && !WR_DATA_I[CFQ_ST_OVF]) begin
      st_nxt.ovf = 1'b0;
    end
    if (st_r.flush[CFQ_Q_EVQ]) begin
      st_nxt.ovf = 1'b0;
    end
    // overflow set, wins over a clear
    if (drop[CFQ_Q_EVQ]) begin
      st_nxt.ovf = 1'b1;
    end

    // interrupt events and edge history
    st_nxt.ne_prev     = evq_ne;
    st_nxt.full_prev   = evq_full;
    ev[CFQ_IRQ_OVF]    = drop[CFQ_Q_EVQ];
    ev[CFQ_IRQ_NE]     = evq_ne & ~st_r.ne_prev;
    ev[CFQ_IRQ_FULL]   = evq_full & ~st_r.full_prev;
    ev[CFQ_IRQ_FLUSH]  = |st_r.flush;
    if (WR_I && ADDR_I == CFQ_ADR_IRQ_CLR) begin
      clr = WR_DATA_I[CFQ_IRQ_W-1:0];
    end
    if (WR_I && ADDR_I == CFQ_ADR_IRQ_EN) begin
      st_nxt.irq_en = WR_DATA_I[CFQ_IRQ_W-1:0];
    end
    // set wins over clear
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;

    // read data, only in the cycle after the read strobe
    st_nxt.rd_data = 32'h0000_0000;
    if (RD_I) begin
      if (ADDR_I == CFQ_ADR_MODE) begin
        st_nxt.rd_data[CFQ_MODE_LSB +: 3] = st_r.mode;
      end
      if (ADDR_I == CFQ_ADR_EVQ_STAT) begin
        st_nxt.rd_data[CFQ_ST_NE]   = evq_ne;
        st_nxt.rd_data[CFQ_ST_HALF] = evq_half;
        st_nxt.rd_data[CFQ_ST_FULL] = evq_full;
        st_nxt.rd_data[CFQ_ST_OVF]  = st_r.ovf;
      end
      if (ADDR_I == CFQ_ADR_IRQ_STAT) begin
        st_nxt.rd_data[CFQ_IRQ_W-1:0] = st_r.irq_stat;
      end
      if (ADDR_I == CFQ_ADR_IRQ_EN) begin
        st_nxt.rd_data[CFQ_IRQ_W-1:0] = st_r.irq_en;
      end
      for (int q = 0; q < CFQ_NQ; q++) begin
        if (bank_hit_f(ADDR_I, CFQ_ADR_CTRL_BASE, q)) begin
          st_nxt.rd_data[CFQ_CTL_DEPTH +: CFQ_PTR_W] = st_r.depth[q];
          st_nxt.rd_data[CFQ_CTL_FLUSH]              = st_r.flush[q];
          st_nxt.rd_data[CFQ_CTL_ADV]                = st_r.adv[q];
          st_nxt.rd_data[CFQ_CTL_DIR]                = dir_eff[q];
        end
        // one user address word per queue
        if (bank_hit_f(ADDR_I, CFQ_ADR_UA_BASE, q)) begin
          st_nxt.rd_data = dir_eff[q] ? ua_f(q, head[q]) : ua_f(q, tail[q]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r          <= '0;
      st_r.mode     <= CFQ_MODE_RST;
      st_r.depth    <= {CFQ_NQ{CFQ_DEPTH_RST}};
      st_r.irq_stat <= CFQ_IRQ_RST;
      st_r.irq_en   <= CFQ_IRQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // user addresses valid only outside configuration mode
  assign CONFIG_MODE_O = cfg_mode;
  assign RD_DATA_O     = st_r.rd_data;
  assign IRQ_O         = |(st_r.irq_stat & st_r.irq_en);

endmodule

/* cfq_top_sva.sv */
// assertions on the register port of the queue status block
// assumes a bind to cfq_top, one clock, synchronous active-low reset
`timescale 1ns/1ns

module cfq_top_sva
  import cfq_pkg::*;
#(
  parameter logic [31:0] RAM_BASE = 32'h0000_0000
)(
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // register port
  input  wire logic [CFQ_ADDR_W-1:0] ADDR_I,
  input  wire logic [31:0]           WR_DATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  input  wire logic [31:0]           RD_DATA_O,
  // engine and system
  input  wire logic [CFQ_NQ-1:0]     HW_EVENT_I,
  input  wire logic                  IRQ_O,
  input  wire logic                  CONFIG_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // helpers: flush of the event queue, mode code written
  wire flush0 = WR_I && ADDR_I == CFQ_ADR_CTRL_BASE && WR_DATA_I[CFQ_CTL_FLUSH];
  wire cfgw   = WR_DATA_I[2:0] == CFQ_MODE_CONFIG;
  sequence rd_at(logic [11:0] a);
    RD_I && ADDR_I == a;
  endsequence

  chk_rd_quiet: assert property (!RD_I |=> RD_DATA_O == 32'h0)
    else $error("read data outside its slot");
  chk_stat_high: assert property (rd_at(CFQ_ADR_EVQ_STAT) |=> RD_DATA_O[31:4] == 28'h0)
    else $error("status upper bits not zero");
  chk_mode_set: assert property (WR_I && ADDR_I == CFQ_ADR_MODE |=> CONFIG_MODE_O == $past(cfgw))
    else $error("mode output wrong after write");
  chk_mode_read: assert property (rd_at(CFQ_ADR_MODE) |=>
    (RD_DATA_O[2:0] == CFQ_MODE_CONFIG) == CONFIG_MODE_O)
    else $error("mode read disagrees with output");
  chk_dir_fixed: assert property (rd_at(CFQ_ADR_CTRL_BASE + 12'h040) |=> RD_DATA_O[CFQ_CTL_DIR])
    else $error("transmit queue direction not fixed");
  chk_flush_clr: assert property (flush0 ##2 rd_at(CFQ_ADR_CTRL_BASE) |=> !RD_DATA_O[CFQ_CTL_FLUSH])
    else $error("flush request did not clear");
  chk_flush_stat: assert property (flush0 ##1 (!HW_EVENT_I[0]) [*2] ##1 rd_at(CFQ_ADR_EVQ_STAT)
    |=> RD_DATA_O[3:0] == 4'h0)
    else $error("status not empty after flush");
  chk_flush_ua: assert property (flush0 ##1 (!WR_I) [*4] ##1 rd_at(CFQ_ADR_UA_BASE) |=> RD_DATA_O == RAM_BASE)
    else $error("event queue address not reset");
  chk_irq_off: assert property (WR_I && ADDR_I == CFQ_ADR_IRQ_EN && WR_DATA_I[3:0] == 4'h0
    |=> !IRQ_O)
    else $error("interrupt high with all masked");

  // main scenarios
  cov_flush: cover property (flush0);
  cov_ovf: cover property (rd_at(CFQ_ADR_EVQ_STAT) ##1 RD_DATA_O[CFQ_ST_OVF]);
  cov_irq: cover property ($rose(IRQ_O));
endmodule

bind cfq_top cfq_top_sva #(.RAM_BASE(RAM_BASE)) sva_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .HW_EVENT_I(HW_EVENT_I),
  .IRQ_O(IRQ_O), .CONFIG_MODE_O(CONFIG_MODE_O)
);

/* testbench.sv */
// register-level tests of the queue status and user address block
// assumes cfq_top, the engine stand-in and the bound checker
`timescale 1ns/1ns

module testbench;
  import cfq_pkg::*;
  localparam logic [31:0] RB = 32'h0000_1000;
  localparam logic [31:0] SB = 32'h0000_0048;
  localparam logic [31:0] QS = 32'h0000_0900;
  localparam logic [11:0] CB = CFQ_ADR_CTRL_BASE;
  localparam logic [11:0] UB = CFQ_ADR_UA_BASE;

  logic                  CLK_I = 1'b0;
  logic                  RST_N_I = 1'b0;
  logic [CFQ_ADDR_W-1:0] ADDR_I = '0;
  logic [31:0]           WR_DATA_I = '0;
  logic                  WR_I = 1'b0;
  logic                  RD_I = 1'b0;
  logic [31:0]           RD_DATA_O;
  logic [CFQ_NQ-1:0]     HW_EVENT_I;
  logic                  IRQ_O;
  logic                  CONFIG_MODE_O;
  int                    err_count = 0;
  int                    n_checks = 0;
  logic [31:0]           v;
  logic                  irq;
  logic                  cm;

  always #20 CLK_I = ~CLK_I;

  cfq_top #(.RAM_BASE(RB), .SLOT_BYTES(SB), .QUEUE_STRIDE(QS)) dut_u (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .HW_EVENT_I(HW_EVENT_I),
    .IRQ_O(IRQ_O), .CONFIG_MODE_O(CONFIG_MODE_O)
  );
  cfq_engine eng_u (.clk_i(CLK_I), .event_o(HW_EVENT_I));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access; a write may be followed at once by a read of the same place
  task automatic bus(input bit w, input bit rb, input logic [11:0] a, input logic [31:0] d);
    ADDR_I <= a;
    WR_DATA_I <= d;
    WR_I <= w;
    RD_I <= !w;
    @(posedge CLK_I);
    if (w && rb) begin
      WR_I <= 1'b0;
      RD_I <= 1'b1;
      @(posedge CLK_I);
    end
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    #1;
    v = RD_DATA_O;
    irq = IRQ_O;
    cm = CONFIG_MODE_O;
    @(posedge CLK_I);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b0, a, 32'h0);
    check(v, exp);
  endtask

  // slot address of queue q
  function automatic logic [31:0] ua(input int q, input int s);
    return RB + QS * 32'(q) + SB * 32'(s);
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog, far beyond the under two hundred cycles of the tests
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    rchk(CFQ_ADR_MODE, 32'h4);
    check({31'h0, cm}, 32'h1);
    rchk(CFQ_ADR_EVQ_STAT, 32'h0);
    // depth 4 everywhere, fifo 1 transmit, then leave configuration
    for (int q = 0; q < CFQ_NQ; q++) wr(CB + 12'(4 * q), {8'h03, 16'h0, q == 1, 7'h0});
    // user addresses are read only after leaving configuration
    wr(CFQ_ADR_MODE, 32'h0);
    check({31'h0, cm}, 32'h0);
    wr(CB, 32'h0700_0000);
    rchk(CB, 32'h0300_0000);
    rchk(CB + 12'h040, 32'h0300_0080);
    for (int n = 1; n <= 4; n++) begin
      eng_u.send(17'h1, 1, 1'b0);
      rchk(CFQ_ADR_EVQ_STAT, {28'h0, 1'b0, n == 4, 2 * n >= 4, 1'b1});
    end
    eng_u.send(17'h1, 1, 1'b0);
    rchk(CFQ_ADR_EVQ_STAT, 32'hF);
    wr(CFQ_ADR_EVQ_STAT, 32'hFFFF_FFFF);
    rchk(CFQ_ADR_EVQ_STAT, 32'hF);
    rchk(UB, ua(0, 0));
    wr(CB, 32'h100);
    rchk(CFQ_ADR_EVQ_STAT, 32'hB);
    rchk(UB, ua(0, 1));
    check({31'h0, irq}, 32'h0);
    wr(CFQ_ADR_IRQ_EN, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(CFQ_ADR_IRQ_CLR, 32'h1);
    check({31'h0, irq}, 32'h0);
    rchk(CFQ_ADR_IRQ_STAT, 32'h6);
    rchk(CFQ_ADR_IRQ_CLR, 32'h0);
    bus(1'b1, 1'b1, CB, 32'h400);
    check(v & 32'h400, 32'h400);
    rchk(CFQ_ADR_EVQ_STAT, 32'h0);
    rchk(UB, ua(0, 0));
    rchk(CFQ_ADR_IRQ_STAT, 32'hE);
    wr(CFQ_ADR_IRQ_EN, 32'h0);
    wr(CFQ_ADR_IRQ_CLR, 32'hF);
    rchk(CFQ_ADR_IRQ_STAT, 32'h0);
    // transmit fifo: software fills the head, engine consumes the tail
    wr(CB + 12'h004, 32'h100);
    wr(CB + 12'h004, 32'h100);
    eng_u.send(17'h2, 1, 1'b0);
    rchk(UB + 12'h004, ua(1, 2));
    // receive fifo: engine stores at the head, software reads the tail
    eng_u.send(17'h4, 2, 1'b1);
    rchk(UB + 12'h008, ua(2, 0));
    wr(CB + 12'h008, 32'h100);
    repeat (2) @(posedge CLK_I);
    rchk(UB + 12'h008, ua(2, 1));
    wr(CB + 12'h040, 32'h100);
    repeat (2) @(posedge CLK_I);
    rchk(UB + 12'h040, ua(16, 1));
    for (int q = 3; q < 16; q++) rchk(UB + 12'(4 * q), ua(q, 0));
    rchk(12'h004, 32'h0);
    conclude();
  end
endmodule
